// File: hw/dcpm_apb_master.sv
// APB master that carries one device register access per start pulse.
`timescale 1ns/100ps
`default_nettype none
module dcpm_apb_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic err,
  output logic [31:0] rdata,
  output logic m_psel,
  output logic m_penable,
  output logic m_pwrite,
  output logic [31:0] m_paddr,
  output logic [31:0] m_pwdata,
  input wire logic [31:0] m_prdata,
  input wire logic m_pready,
  input wire logic m_pslverr
);
  // ==========================================================================
  // Transfer phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_psel <= 1'b0;
      m_penable <= 1'b0;
      m_pwrite <= 1'b0;
      m_paddr <= 32'h0;
      m_pwdata <= 32'h0;
      done <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0;
    end else begin
      done <= 1'b0;
      if (start && !m_psel) begin
        m_psel <= 1'b1;
        m_pwrite <= wr;
        m_paddr <= addr;
        m_pwdata <= wdata;
      end else if (m_psel && !m_penable) begin
        m_penable <= 1'b1;
      end else if (m_psel && m_penable && m_pready) begin
        // The request is released only at the edge that sees pready.
        m_psel <= 1'b0;
        m_penable <= 1'b0;
        done <= 1'b1;
        err <= m_pslverr;
        rdata <= m_prdata;
      end
    end
  end

  a_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
    m_penable && !m_pready |=> $stable(m_paddr) && $stable(m_pwdata) && m_psel && m_penable)
    else $error("Master dropped a pending request.");
endmodule
`default_nettype wire

// File: hw/dcpm_ctrl.sv
// Host controller that walks the display clock-off and engine-off allow/disallow sequences.
// What this block does
// - Context program must be loaded before permitting clock-off; engine-off resets it.
// - Audio idle, external outputs off, backlight not on utility pin first.
// - Deep-sleep idle-frame count is zero while clock-off idle enabled.
// - Mid and deep power states are never permitted with clock-off idle.
// - Withdraw clock-off before mode set or PLL, buffer, aux programming.
// - Permit: zero state enable, self refresh off, zero idle count, on.
// - Early exit line is ceil(200us over line time) plus one, enabled.
// - Setting the clock-off enable bit is the last permit step.
// - Withdraw: zero status flag, clear enable, wait full exit time.
// - After exit: self refresh off, restore idle count, re-enable if needed.
// - Engine-off permit: mid state disallowed first, allow bit set last.
// - Engine-off withdraw: clear allow bit, then program must be restored.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dcpm_params.svh"
module dcpm_ctrl #(
  parameter int EXIT_CYC = `DCPM_EXIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic m_psel,
  output logic m_penable,
  output logic m_pwrite,
  output logic [31:0] m_paddr,
  output logic [31:0] m_pwdata,
  input wire logic [31:0] m_prdata,
  input wire logic m_pready,
  input wire logic m_pslverr
);
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] dsc_word(input logic co, input logic eo, input logic flag);
    logic [31:0] w;
    w = 32'h0;
    w[`DCPM_DSC_CO_BIT] = co;
    w[`DCPM_DSC_FLAG_BIT] = flag;
    w[`DCPM_DSC_EO_BIT] = eo;
    return w;
  endfunction

  function automatic logic [31:0] src_word(input logic en, input logic [3:0] idle);
    logic [31:0] w;
    w = 32'h0;
    w[`DCPM_SRC_EN_BIT] = en;
    w[`DCPM_SRC_IDLE_LSB +: 4] = idle;
    return w;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a == `DCPM_R_CTRL || a == `DCPM_R_CFG || a == `DCPM_R_STAT || a == `DCPM_R_RDBK;
  endfunction

  // ==========================================================================
  // State
  dcpm_pkg::dcpm_state_t state_q;
  logic [3:0] ctrl_q;
  logic [31:0] cfg_q;
  logic co_on_q, eo_on_q, err_q, issued_q;
  logic [17:0] rem_q;
  logic [15:0] cnt_q, exl_q;
  logic [12:0] wait_q;
  logic [31:0] rdbk_q;
  logic op_v, op_wr, m_start, m_done, m_err;
  logic [31:0] op_addr, op_data, m_rdata;
  logic wr_acc, co_ok;
  logic [15:0] line_ns;
  logic [3:0] idle_rst;

  assign wr_acc = psel && penable && pready && pwrite;
  assign line_ns = cfg_q[`DCPM_CFG_LINE_LSB +: 16];
  assign idle_rst = cfg_q[`DCPM_CFG_IDLE_LSB +: 4];
  // Preconditions are asserted by software through the configuration word and the program bit.
  assign co_ok = ctrl_q[`DCPM_CTRL_PROG] && !cfg_q[`DCPM_CFG_PORT_BIT]
    && !cfg_q[`DCPM_CFG_PIPE_BIT]
    && cfg_q[`DCPM_CFG_AUDIO_OFF] && cfg_q[`DCPM_CFG_EXT_OFF] && cfg_q[`DCPM_CFG_BL_OK]
    && !eo_on_q && line_ns != 16'h0;

  // ==========================================================================
  // Software register port, answering in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && !penable && !pready) begin
        pready <= 1'b1;
        pslverr <= !mapped(paddr);
        case (paddr)
          `DCPM_R_CTRL: prdata <= {28'h0, ctrl_q};
          `DCPM_R_CFG: prdata <= cfg_q;
          `DCPM_R_STAT: prdata <= {exl_q, 12'h0, err_q, state_q != dcpm_pkg::S_IDLE,
            eo_on_q, co_on_q};
          `DCPM_R_RDBK: prdata <= rdbk_q;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 4'h0;
    end else if (state_q == dcpm_pkg::S_ED_CLEAR && m_done) begin
      // Engine-off discards the context program, so it must be loaded again.
      ctrl_q[`DCPM_CTRL_PROG] <= 1'b0;
    end else if (wr_acc && paddr == `DCPM_R_CTRL) begin
      // Software loads the context program itself and reports it through the program bit.
      ctrl_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 32'h0;
    end else if (wr_acc && paddr == `DCPM_R_CFG) begin
      cfg_q <= pwdata;
    end
  end

  // Refusal flag: a new refusal or bus error wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if ((m_done && m_err) || (state_q == dcpm_pkg::S_IDLE && !co_on_q
        && ctrl_q[`DCPM_CTRL_CO_REQ] && !co_ok && !(co_on_q && !ctrl_q[`DCPM_CTRL_CO_REQ]))) begin
      err_q <= 1'b1;
    end else if (wr_acc && paddr == `DCPM_R_STAT && pwdata[`DCPM_STAT_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Device access for each sequence step
  always_comb begin
    op_v = 1'b1;
    op_wr = 1'b1;
    op_addr = `DCPM_DEV_DSC;
    op_data = 32'h0;
    case (state_q)
      dcpm_pkg::S_CA_DSC0: op_data = dsc_word(1'b0, 1'b0, 1'b0);
      dcpm_pkg::S_CA_SRF_OFF: begin
        op_addr = `DCPM_DEV_SRC;
        op_data = src_word(1'b0, idle_rst);
      end
      dcpm_pkg::S_CA_SRF_ZERO: begin
        op_addr = `DCPM_DEV_SRC;
        op_data = src_word(1'b0, 4'h0);
      end
      dcpm_pkg::S_CA_SRF_ON: begin
        op_addr = `DCPM_DEV_SRC;
        op_data = src_word(1'b1, 4'h0);
      end
      dcpm_pkg::S_CA_EXL: begin
        op_addr = `DCPM_DEV_EXL;
        op_data = {16'h0, exl_q};
        op_data[`DCPM_EXL_EN_BIT] = 1'b1;
      end
      dcpm_pkg::S_CA_EN: op_data = dsc_word(1'b1, 1'b0, 1'b0);
      dcpm_pkg::S_CD_FLAG: op_data = dsc_word(1'b1, eo_on_q, 1'b0);
      dcpm_pkg::S_CD_EN: op_data = dsc_word(1'b0, eo_on_q, 1'b0);
      dcpm_pkg::S_CD_SRF_OFF: begin
        op_addr = `DCPM_DEV_SRC;
        op_data = src_word(1'b0, 4'h0);
      end
      dcpm_pkg::S_CD_SRF_IDLE: begin
        op_addr = `DCPM_DEV_SRC;
        op_data = src_word(1'b0, idle_rst);
      end
      dcpm_pkg::S_CD_SRF_ON: begin
        op_addr = `DCPM_DEV_SRC;
        op_data = src_word(1'b1, idle_rst);
      end
      dcpm_pkg::S_EA_DSC0: op_data = dsc_word(1'b0, 1'b0, 1'b0);
      dcpm_pkg::S_EA_ALLOW: op_data = dsc_word(1'b0, 1'b1, 1'b0);
      dcpm_pkg::S_ED_CLEAR: op_data = dsc_word(1'b0, 1'b0, 1'b0);
      dcpm_pkg::S_RB: op_wr = 1'b0;
      default: op_v = 1'b0;
    endcase
  end

  assign m_start = op_v && !issued_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issued_q <= 1'b0;
    end else if (m_done) begin
      issued_q <= 1'b0;
    end else if (m_start) begin
      issued_q <= 1'b1;
    end
  end

  dcpm_apb_master dcpm_apb_master_inst (
    .pclk(pclk),
    .presetn(presetn),
    .start(m_start),
    .wr(op_wr),
    .addr(op_addr),
    .wdata(op_data),
    .done(m_done),
    .err(m_err),
    .rdata(m_rdata),
    .m_psel(m_psel),
    .m_penable(m_penable),
    .m_pwrite(m_pwrite),
    .m_paddr(m_paddr),
    .m_pwdata(m_pwdata),
    .m_prdata(m_prdata),
    .m_pready(m_pready),
    .m_pslverr(m_pslverr)
  );

  // ==========================================================================
  // Sequencer
  // Withdrawals are served before permits in idle, though a permit sequence already under way is finished first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dcpm_pkg::S_IDLE;
    end else begin
      case (state_q)
        dcpm_pkg::S_IDLE: begin
          if (co_on_q && !ctrl_q[`DCPM_CTRL_CO_REQ]) begin
            state_q <= dcpm_pkg::S_CD_FLAG;
          end else if (eo_on_q && !ctrl_q[`DCPM_CTRL_EO_REQ]) begin
            state_q <= dcpm_pkg::S_ED_CLEAR;
          end else if (!co_on_q && ctrl_q[`DCPM_CTRL_CO_REQ] && !err_q && co_ok) begin
            state_q <= dcpm_pkg::S_CALC;
          end else if (!eo_on_q && ctrl_q[`DCPM_CTRL_EO_REQ] && !err_q && !co_on_q) begin
            state_q <= dcpm_pkg::S_EA_DSC0;
          end
        end
        dcpm_pkg::S_CALC: begin
          if (rem_q <= 18'(line_ns)) begin
            state_q <= dcpm_pkg::S_CA_DSC0;
          end
        end
        dcpm_pkg::S_CD_WAIT: begin
          if (wait_q == 13'(EXIT_CYC - 1)) begin
            state_q <= dcpm_pkg::S_CD_SRF_OFF;
          end
        end
        default: begin
          if (m_done) begin
            case (state_q)
              dcpm_pkg::S_CA_DSC0: state_q <= dcpm_pkg::S_CA_SRF_OFF;
              dcpm_pkg::S_CA_SRF_OFF: state_q <= dcpm_pkg::S_CA_SRF_ZERO;
              dcpm_pkg::S_CA_SRF_ZERO: state_q <= dcpm_pkg::S_CA_SRF_ON;
              dcpm_pkg::S_CA_SRF_ON: state_q <= dcpm_pkg::S_CA_EXL;
              dcpm_pkg::S_CA_EXL: state_q <= dcpm_pkg::S_CA_EN;
              dcpm_pkg::S_CD_FLAG: state_q <= dcpm_pkg::S_CD_EN;
              dcpm_pkg::S_CD_EN: state_q <= dcpm_pkg::S_CD_WAIT;
              dcpm_pkg::S_CD_SRF_OFF: state_q <= dcpm_pkg::S_CD_SRF_IDLE;
              dcpm_pkg::S_CD_SRF_IDLE: state_q <= ctrl_q[`DCPM_CTRL_SRF_NEED] ?
                dcpm_pkg::S_CD_SRF_ON : dcpm_pkg::S_RB;
              dcpm_pkg::S_EA_DSC0: state_q <= dcpm_pkg::S_EA_ALLOW;
              default: state_q <= state_q == dcpm_pkg::S_RB ? dcpm_pkg::S_IDLE : dcpm_pkg::S_RB;
            endcase
          end
        end
      endcase
    end
  end

  // Exit line: repeated subtraction counts one less than the rounded-up quotient, then two is added.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_q <= 18'h0;
      cnt_q <= 16'h0;
      exl_q <= 16'h0;
    end else if (state_q == dcpm_pkg::S_IDLE) begin
      rem_q <= 18'(`DCPM_EXIT_NS);
      cnt_q <= 16'h0;
    end else if (state_q == dcpm_pkg::S_CALC) begin
      if (rem_q > 18'(line_ns)) begin
        rem_q <= rem_q - 18'(line_ns);
        cnt_q <= cnt_q + 16'h1;
      end else begin
        exl_q <= cnt_q + 16'h2;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 13'h0;
    end else if (state_q == dcpm_pkg::S_CD_WAIT) begin
      wait_q <= wait_q + 13'h1;
    end else begin
      wait_q <= 13'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      co_on_q <= 1'b0;
      eo_on_q <= 1'b0;
    end else if (m_done) begin
      if (state_q == dcpm_pkg::S_CA_EN) co_on_q <= 1'b1;
      if (state_q == dcpm_pkg::S_CD_EN) co_on_q <= 1'b0;
      if (state_q == dcpm_pkg::S_EA_ALLOW) eo_on_q <= 1'b1;
      if (state_q == dcpm_pkg::S_ED_CLEAR) eo_on_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdbk_q <= 32'h0;
    end else if (m_done && state_q == dcpm_pkg::S_RB) begin
      rdbk_q <= m_rdata;
    end
  end

  // ==========================================================================
  // Checks
  logic [12:0] hold_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_q <= 13'h0;
    else hold_q <= state_q == dcpm_pkg::S_CD_WAIT ? hold_q + 13'h1 : 13'h0;
  end

  a_exit_wait_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(state_q == dcpm_pkg::S_CD_WAIT) |-> $past(hold_q) == 13'(EXIT_CYC - 1))
    else $error("Exit wait has wrong length.");
  a_co_prog_loaded: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(co_on_q) |-> $past(ctrl_q[`DCPM_CTRL_PROG], 2))
    else $error("Clock-off permitted without a loaded program.");
  a_co_first_port: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == dcpm_pkg::S_CALC) |-> !cfg_q[`DCPM_CFG_PORT_BIT] && !cfg_q[`DCPM_CFG_PIPE_BIT])
    else $error("Clock-off started on an unsupported port.");
  a_exl_value: assert property (@(posedge pclk) disable iff (!presetn)
    m_start && state_q == dcpm_pkg::S_CA_EXL |-> op_data[15:0] >= 16'h2
      && 32'(op_data[15:0] - 16'h1) * 32'(line_ns) >= 32'(`DCPM_EXIT_NS)
      && 32'(op_data[15:0] - 16'h2) * 32'(line_ns) < 32'(`DCPM_EXIT_NS))
    else $error("Early exit line count is wrong.");
  a_zero_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == dcpm_pkg::S_CA_SRF_OFF) |-> $past(state_q) == dcpm_pkg::S_CA_DSC0)
    else $error("Self refresh touched before state enable cleared.");
  a_enable_last: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(co_on_q) |-> $past(state_q) == dcpm_pkg::S_CA_EN ##1 state_q == dcpm_pkg::S_RB)
    else $error("Clock-off enable was not the last permit step.");
  a_no_mid_state: assert property (@(posedge pclk) disable iff (!presetn)
    m_start && op_addr == `DCPM_DEV_DSC |-> op_data[1:0] == 2'h0)
    else $error("Mid or deep state enabled by the controller.");
  a_flag_then_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == dcpm_pkg::S_CD_EN) |-> $past(state_q) == dcpm_pkg::S_CD_FLAG)
    else $error("Enable cleared before status flag.");
  a_eo_drops_prog: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(eo_on_q) |-> !ctrl_q[`DCPM_CTRL_PROG])
    else $error("Program flag kept across engine-off.");
  a_eo_excl_co: assert property (@(posedge pclk) disable iff (!presetn)
    !(eo_on_q && co_on_q))
    else $error("Both power states permitted at once.");

  c_co_allow: cover property (@(posedge pclk) disable iff (!presetn) $rose(co_on_q));
  c_co_withdraw: cover property (@(posedge pclk) disable iff (!presetn) $fell(co_on_q));
  c_eo_cycle: cover property (@(posedge pclk) disable iff (!presetn) $fell(eo_on_q));
  c_refused: cover property (@(posedge pclk) disable iff (!presetn) $rose(err_q));
endmodule
`default_nettype wire

// File: hw/dcpm_params.svh
// Constants of the display power-state controller: timing, own register map, device map.
`ifndef DCPM_PARAMS_SVH
`define DCPM_PARAMS_SVH
// ==========================================================================
// Timing
`define DCPM_CLK_NS 50
`define DCPM_EXIT_NS 200000
`define DCPM_EXIT_CYC ((`DCPM_EXIT_NS + `DCPM_CLK_NS - 1) / `DCPM_CLK_NS)
// ==========================================================================
// Own registers on the software APB port
`define DCPM_R_CTRL 12'h000
`define DCPM_R_CFG 12'h004
`define DCPM_R_STAT 12'h008
`define DCPM_R_RDBK 12'h00C
`define DCPM_CTRL_CO_REQ 0
`define DCPM_CTRL_EO_REQ 1
`define DCPM_CTRL_PROG 2
`define DCPM_CTRL_SRF_NEED 3
`define DCPM_CFG_LINE_LSB 0
`define DCPM_CFG_IDLE_LSB 16
`define DCPM_CFG_PORT_BIT 20
`define DCPM_CFG_PIPE_BIT 21
`define DCPM_CFG_AUDIO_OFF 24
`define DCPM_CFG_EXT_OFF 25
`define DCPM_CFG_BL_OK 26
`define DCPM_STAT_CO_ON 0
`define DCPM_STAT_EO_ON 1
`define DCPM_STAT_BUSY 2
`define DCPM_STAT_ERR 3
`define DCPM_STAT_EXL_LSB 16
// ==========================================================================
// Device registers reached over the master port
`define DCPM_DEV_DSC 32'h0000_0100
`define DCPM_DEV_SRC 32'h0000_0200
`define DCPM_DEV_EXL 32'h0000_0300
`define DCPM_DSC_CO_BIT 2
`define DCPM_DSC_FLAG_BIT 3
`define DCPM_DSC_EO_BIT 4
`define DCPM_SRC_EN_BIT 31
`define DCPM_SRC_IDLE_LSB 8
`define DCPM_EXL_EN_BIT 31
`endif

// File: hw/dcpm_pkg.sv
// Types shared by the display power-state controller.
`default_nettype none
package dcpm_pkg;
  typedef enum logic [4:0] {
    S_IDLE, S_CALC, S_CA_DSC0, S_CA_SRF_OFF, S_CA_SRF_ZERO, S_CA_SRF_ON, S_CA_EXL, S_CA_EN,
    S_CD_FLAG, S_CD_EN, S_CD_WAIT, S_CD_SRF_OFF, S_CD_SRF_IDLE, S_CD_SRF_ON,
    S_EA_DSC0, S_EA_ALLOW, S_ED_CLEAR, S_RB
  } dcpm_state_t;
endpackage
`default_nettype wire

// File: test/dcpm_ctrl_test.sv
// Self-checking testbench of the display power-state controller.
`timescale 1ns/100ps
`default_nettype none
`include "dcpm_params.svh"
module dcpm_ctrl_test;
  // ==========================================================================
  // Harness
  localparam int EXIT = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic m_psel;
  logic m_penable;
  logic m_pwrite;
  logic [31:0] m_paddr;
  logic [31:0] m_pwdata;
  logic [31:0] m_prdata;
  logic m_pready;
  logic m_pslverr;
  logic [1:0] wait_cyc = 2'h0;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [65:0] expq[$];
  logic [63:0] devq[$];
  int wtime[$];
  logic [65:0] e;
  always #25 pclk = ~pclk;
  dcpm_ctrl #(.EXIT_CYC(EXIT)) dcpm_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .m_psel(m_psel), .m_penable(m_penable),
    .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_prdata(m_prdata),
    .m_pready(m_pready), .m_pslverr(m_pslverr));
  dcpm_dev_model dcpm_dev_model_inst (.pclk(pclk), .presetn(presetn), .psel(m_psel),
    .penable(m_penable), .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata),
    .prdata(m_prdata), .pready(m_pready), .pslverr(m_pslverr), .wait_cyc(wait_cyc));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Monitors of both ports
  always @(posedge pclk) begin
    cyc++;
    if (pready === 1'b1) begin
      if (expq.size() == 0) check(64'h1, 64'h0);
      else begin
        e = expq.pop_front();
        if (e[65:33] !== 33'h0) check(64'({pslverr, prdata} & e[65:33]), 64'(e[32:0] & e[65:33]));
      end
    end
    if ((m_psel & m_penable & m_pready & m_pwrite) === 1'b1) begin
      wtime.push_back(cyc);
      if (devq.size() == 0) check({m_paddr, m_pwdata}, ~{m_paddr, m_pwdata});
      else check({m_paddr, m_pwdata}, devq.pop_front());
    end
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Bus tasks
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] m, input logic [32:0] x, output logic [31:0] r);
    @(posedge pclk);
    expq.push_back({m, x});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, 33'h1_0000_0000, 33'h0, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, {1'b1, m}, {1'b0, x}, r);
  endtask
  task automatic dx(input logic [31:0] a, input logic [31:0] d);
    devq.push_back({a, d});
  endtask
  task automatic dx_permit(input logic [3:0] idle, input logic [15:0] lines);
    dx(`DCPM_DEV_DSC, 32'h0);
    dx(`DCPM_DEV_SRC, {20'h0, idle, 8'h0});
    dx(`DCPM_DEV_SRC, 32'h0);
    dx(`DCPM_DEV_SRC, 32'h8000_0000);
    dx(`DCPM_DEV_EXL, {16'h8000, lines});
    dx(`DCPM_DEV_DSC, 32'h4);
  endtask
  // Device traffic drains first, then busy is polled; both waits are bounded.
  task automatic settle();
    logic [31:0] r;
    r = 32'h4;
    for (int i = 0; i < 3000 && devq.size() != 0; i++) @(posedge pclk);
    for (int i = 0; i < 400 && r[2] !== 1'b0; i++) begin
      xfer(1'b0, `DCPM_R_STAT, 32'h0, 33'h0, 33'h0, r);
    end
  endtask
  // ==========================================================================
  // Scenarios
  initial begin
    logic [31:0] r;
    logic [31:0] cfg;
    logic [31:0] ctl;
    logic [31:0] ok;
    logic [3:0] idle;
    logic [15:0] lines;
    int lt;
    int n;
    void'($urandom(97));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(12'(i * 4), 32'hFFFF_FFFF, 32'h0);
    xfer(1'b0, 12'h010, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000, r);
    wr(`DCPM_R_RDBK, 32'h5A5A_5A5A);
    rd(`DCPM_R_RDBK, 32'hFFFF_FFFF, 32'h0);
    lt = 20000 + $urandom_range(0, 30000);
    idle = 4'($urandom_range(1, 15));
    lines = 16'((200000 + lt - 1) / lt + 1);
    ok = {5'h0, 3'h7, 4'h0, idle, 16'(lt)};
    wr(`DCPM_R_CFG, ok);
    wait_cyc <= 2'($urandom_range(0, 3));
    dx_permit(idle, lines);
    wr(`DCPM_R_CTRL, 32'hD);
    settle();
    rd(`DCPM_R_STAT, 32'hFFFF_000F, {lines, 16'h1});
    rd(`DCPM_R_RDBK, 32'hFFFF_FFFF, 32'hC);
    n = wtime.size();
    dx(`DCPM_DEV_DSC, 32'h4);
    dx(`DCPM_DEV_DSC, 32'h0);
    dx(`DCPM_DEV_SRC, 32'h0);
    dx(`DCPM_DEV_SRC, {20'h0, idle, 8'h0});
    dx(`DCPM_DEV_SRC, {1'b1, 19'h0, idle, 8'h0});
    wr(`DCPM_R_CTRL, 32'hC);
    settle();
    check(64'(wtime[n + 2] - wtime[n + 1] >= EXIT), 64'h1);
    rd(`DCPM_R_STAT, 32'h7, 32'h0);
    wait_cyc <= 2'h3;
    dx(`DCPM_DEV_DSC, 32'h0);
    dx(`DCPM_DEV_DSC, 32'h10);
    wr(`DCPM_R_CTRL, 32'h6);
    settle();
    rd(`DCPM_R_STAT, 32'h7, 32'h2);
    rd(`DCPM_R_RDBK, 32'hFFFF_FFFF, 32'h10);
    dx(`DCPM_DEV_DSC, 32'h0);
    wr(`DCPM_R_CTRL, 32'h4);
    settle();
    rd(`DCPM_R_CTRL, 32'hF, 32'h0);
    rd(`DCPM_R_STAT, 32'h7, 32'h0);
    // Each pass breaks one precondition of a clock-off permit.
    for (int i = 0; i < 7; i++) begin
      cfg = ok;
      ctl = 32'h5;
      case (i)
        0: ctl = 32'h1;
        1: cfg[20] = 1'b1;
        2: cfg[21] = 1'b1;
        3: cfg[24] = 1'b0;
        4: cfg[25] = 1'b0;
        5: cfg[26] = 1'b0;
        default: cfg[15:0] = 16'h0;
      endcase
      wr(`DCPM_R_CFG, cfg);
      wr(`DCPM_R_CTRL, ctl);
      settle();
      rd(`DCPM_R_STAT, 32'hF, 32'h8);
      wr(`DCPM_R_CTRL, 32'h0);
      wr(`DCPM_R_STAT, 32'h8);
      rd(`DCPM_R_STAT, 32'h8, 32'h0);
    end
    // Second round without the self-refresh need, so no restart write may follow.
    wr(`DCPM_R_CFG, ok);
    dx_permit(idle, lines);
    wr(`DCPM_R_CTRL, 32'h5);
    settle();
    rd(`DCPM_R_STAT, 32'hFFFF_000F, {lines, 16'h1});
    dx(`DCPM_DEV_DSC, 32'h4);
    dx(`DCPM_DEV_DSC, 32'h0);
    dx(`DCPM_DEV_SRC, 32'h0);
    dx(`DCPM_DEV_SRC, {20'h0, idle, 8'h0});
    wr(`DCPM_R_CTRL, 32'h4);
    settle();
    rd(`DCPM_R_STAT, 32'h7, 32'h0);
    check(64'(devq.size()), 64'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

// File: test/dcpm_dev_model.sv
// Behavioural model of the display device register port behind the controller.
`timescale 1ns/100ps
`default_nettype none
`include "dcpm_params.svh"
module dcpm_dev_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] wait_cyc
);
  // ==========================================================================
  // Access timing
  logic [31:0] dsc_q;
  logic [31:0] src_q;
  logic [31:0] exl_q;
  logic [1:0] cnt_q;
  logic hit;
  logic map;
  assign hit = psel && penable && !pready && (cnt_q == wait_cyc);
  assign map = paddr == `DCPM_DEV_DSC || paddr == `DCPM_DEV_SRC || paddr == `DCPM_DEV_EXL;
  // The port keeps answering in clock-off idle, as the core clock runs slow, not stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      pready <= hit;
      cnt_q <= (psel && penable && !hit && !pready) ? cnt_q + 2'h1 : 2'h0;
    end
  end
  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsc_q <= 32'h0;
    end else if (hit && pwrite && paddr == `DCPM_DEV_DSC) begin
      // Writing one cannot raise the status flag; only entry does.
      dsc_q <= {pwdata[31:4], pwdata[3] & dsc_q[3], pwdata[2:0]};
    end else if (dsc_q[2] && src_q[31]) begin
      dsc_q[3] <= 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 32'h0;
      exl_q <= 32'h0;
    end else if (hit && pwrite) begin
      if (paddr == `DCPM_DEV_SRC) src_q <= pwdata;
      if (paddr == `DCPM_DEV_EXL) exl_q <= pwdata;
    end
  end
  // A released data bus shows the inverse of its last value every cycle, so a stale copy returns every second cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= hit && !map;
      if (hit && !pwrite) begin
        prdata <= (paddr == `DCPM_DEV_DSC) ? dsc_q : (paddr == `DCPM_DEV_SRC) ? src_q : exl_q;
      end else begin
        prdata <= ~prdata;
      end
    end
  end
endmodule
`default_nettype wire
